// ===== hdl/dstx_defines.svh
// Offsets, field positions, reset values and counts of the DSSS modulator
`ifndef DSTX_DEFINES_SVH
`define DSTX_DEFINES_SVH
`define DSTX_OFS_CTRL 8'h00
`define DSTX_OFS_SHORT_LEN 8'h04
`define DSTX_OFS_LONG_LEN 8'h08
`define DSTX_OFS_SERVICE 8'h0c
`define DSTX_OFS_LENGTH 8'h10
`define DSTX_OFS_SEED 8'h14
`define DSTX_OFS_STATUS 8'h18
`define DSTX_CTRL_RATE_LSB 0
`define DSTX_CTRL_SCR_DIS 2
`define DSTX_CTRL_WIDE 5
`define DSTX_CTRL_ROT_TX 6
`define DSTX_CTRL_ROT_RX 7
`define DSTX_CTRL_SHORT 8
`define DSTX_SEED_SHORT_LSB 8
`define DSTX_RST_SHORT_LEN 8'h38
`define DSTX_RST_LONG_LEN 8'h80
`define DSTX_RST_LONG_SEED 7'h1b
`define DSTX_RST_SHORT_SEED 7'h6c
`define DSTX_SFD_LONG 16'hf3a0
`define DSTX_SFD_SHORT 16'h05cf
`define DSTX_SFD_BITS 9'h010
`define DSTX_HDR_PROT_BITS 9'h020
`define DSTX_HDR_BITS 9'h030
`define DSTX_CRC_POLY 16'h1021
`define DSTX_CRC_PRESET 16'hffff
`define DSTX_BARKER 11'h0ed
`define DSTX_BARKER_LAST 4'ha
`define DSTX_CCK_LAST 4'h7
`define DSTX_SIG_1M 8'h0a
`define DSTX_SIG_2M 8'h14
`define DSTX_SIG_5M5 8'h37
`define DSTX_SIG_11M 8'h6e
`define DSTX_FIR_N0 8'sh0a
`define DSTX_FIR_N1 8'sh1e
`define DSTX_FIR_W0 8'sh02
`define DSTX_FIR_W1 8'sh28
`define DSTX_DATA_WAIT 4
`define DSTX_TAIL_BITS 8
`endif

// ===== hdl/dstx_pkg.sv
// Types shared by the DSSS modulator
package dstx_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PRE  = 3'b001,
        ST_SFD  = 3'b011,
        ST_HDR  = 3'b010,
        ST_DATA = 3'b110,
        ST_TAIL = 3'b111
    } dstx_state_type;
    typedef enum logic [1:0] {
        MD_DBPSK = 2'b00,
        MD_DQPSK = 2'b01,
        MD_CCK55 = 2'b10,
        MD_CCK11 = 2'b11
    } dstx_mode_type;
endpackage

// ===== hdl/dstx_modulator.sv
// DSSS transmit modulator: framing, scrambler, coder, spreader, FIR
//
// Behaviour
// - Short preamble sync length in symbols comes from a config value.
// - Long preamble sync length in symbols comes from a config value.
// - Two-bit rate select sets signal field and data modulation.
// - Rate 00 DBPSK 1M, 01 DQPSK 2M, 10 CCK 5.5M, 11 CCK 11M.
// - Service field is sent from a configured byte.
// - Length field is sent from a configured 16-bit value.
// - Long sync is ones then delimiter; short is zeros, reversed delimiter.
// - Header check is inverted CRC-16, preset ones, sent MSB first.
// - Payload bits pass unaltered; dummy bits follow before shutdown.
// - Seven-bit self-synchronising scrambler covers every packet part.
// - Scrambler disable bit set to one bypasses scrambling.
// - Scrambler seed comes from long or short preamble seed value.
// - DBPSK differential coding drives the same value on I and Q, except rate 00 data after a short DQPSK header.
// - DQPSK dibits 00,01,11,10 rotate by 0, +90, +180, -90 degrees.
// - Rotation counterclockwise; one bit reverses transmit rotation, the receive bit is only stored.
// - At 1 and 2 Mbps each symbol is spread by the 11-chip Barker word.
// - Preamble is DBPSK; header and data modulations switch in automatically.
// - CCK symbols are eight complex chips, first chip sent first.
// - CCK chips add phase1 all, phase2 odd, phase3 pairs, phase4 quads.
// - CCK phase1 is DQPSK; odd data symbols get an extra half turn.
// - 5.5 Mbps nibbles: dibit one phase1, dibit two sets phases 2 to 4.
// - 11 Mbps bytes: dibits two to four set phases 2 to 4 binary coded.
// - CCK binary map 00,01,10,11 to 0, pi/2, pi, 3pi/2.
// - Phase1 reference after a rate change is the phase of the last header symbol.
// - FIR shapes I and Q; a control bit selects the wider shape.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "dstx_defines.svh"
module dstx_modulator
#(
    parameter int OUT_W = 8,
    parameter int DATA_WAIT = `DSTX_DATA_WAIT,
    parameter int TAIL_BITS = `DSTX_TAIL_BITS
)
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Controller side
    input wire logic TX_ENABLE_LINE,
    input wire logic TX_DATA,
    output logic TX_BIT_REQ,
    output logic TX_ACTIVE,
    // Shaped baseband out
    output logic signed [OUT_W-1:0] TX_I,
    output logic signed [OUT_W-1:0] TX_Q,
    output logic TX_CHIP_VALID
);
    import dstx_pkg::*;

    // Literals cannot be bit-selected, so the code words live here
    localparam logic [10:0] barker_code = `DSTX_BARKER;
    localparam logic [15:0] sfd_long_code = `DSTX_SFD_LONG;
    localparam logic [15:0] sfd_short_code = `DSTX_SFD_SHORT;

    if (OUT_W < 8)
    begin : g_chk_w
        $error("OUT_W below 8 cannot hold the filter sum");
    end
    if (DATA_WAIT < 3 || DATA_WAIT > 7)
    begin : g_chk_wait
        $error("DATA_WAIT must lie in 3..7");
    end
    if (TAIL_BITS < 1 || TAIL_BITS > 255)
    begin : g_chk_tail
        $error("TAIL_BITS must lie in 1..255");
    end

    // Configuration
    logic [1:0] rate_q;
    logic scr_dis_q;
    logic wide_q;
    logic rot_tx_q;
    logic rot_rx_q;
    logic short_q;
    logic [7:0] short_len_q;
    logic [7:0] long_len_q;
    logic [7:0] service_q;
    logic [15:0] length_q;
    logic [6:0] long_seed_q;
    logic [6:0] short_seed_q;
    // Bus
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_data;
    logic hit;
    logic apb_acc;
    logic apb_wr;
    // Pin synchronisers
    logic en_m_q;
    logic en_s_q;
    logic en_d_q;
    logic dat_m_q;
    logic dat_s_q;
    // Sequencer
    dstx_state_type state_q;
    dstx_mode_type mode;
    logic [8:0] bidx_q;
    logic [2:0] gcnt_q;
    logic [2:0] nlast;
    logic [7:0] sym_q;
    logic enc_q;
    logic send_q;
    logic [3:0] chip_q;
    logic [3:0] clast;
    logic [2:0] wait_q;
    logic req_q;
    logic start;
    logic gathering;
    logic take;
    logic sym_end;
    logic cck;
    logic raw;
    logic sbit;
    logic [7:0] sig_code;
    logic [31:0] hdr_word;
    // Coder
    logic [6:0] scr_q;
    logic [15:0] crc_q;
    logic [15:0] crc_next;
    logic [1:0] ph_q;
    logic odd_q;
    logic [1:0] delta;
    logic [1:0] dq;
    logic [1:0] p2;
    logic [1:0] p3;
    logic [1:0] p4;
    logic [1:0] chip_ph;
    // Chips and filter
    logic ci_q;
    logic cq_q;
    logic cv_q;
    logic active_q;
    logic signed [1:0] xi0;
    logic signed [1:0] xq0;
    logic signed [1:0] hi_q [0:2];
    logic signed [1:0] hq_q [0:2];
    logic signed [OUT_W-1:0] i_q;
    logic signed [OUT_W-1:0] q_q;

    // APB: one wait state, effects at the completing edge
    assign apb_acc = PSEL & PENABLE;
    assign apb_wr = apb_acc & pready_q & PWRITE & hit;

    always_comb
    begin
        hit = 1'b1;
        rd_data = 32'h0000_0000;
        case (PADDR)
            `DSTX_OFS_CTRL:
                rd_data = {23'h000000, short_q, rot_rx_q, rot_tx_q, wide_q,
                    2'b00, scr_dis_q, rate_q};
            `DSTX_OFS_SHORT_LEN: rd_data = {24'h000000, short_len_q};
            `DSTX_OFS_LONG_LEN: rd_data = {24'h000000, long_len_q};
            `DSTX_OFS_SERVICE: rd_data = {24'h000000, service_q};
            `DSTX_OFS_LENGTH: rd_data = {16'h0000, length_q};
            `DSTX_OFS_SEED:
                rd_data = {17'h00000, short_seed_q, 1'b0, long_seed_q};
            `DSTX_OFS_STATUS:
                rd_data = {25'h0000000, en_s_q, odd_q, ph_q, state_q};
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= apb_acc & ~pready_q;
            pslverr_q <= apb_acc & ~pready_q & ~hit;
            if (apb_acc && !pready_q && !PWRITE)
            begin
                prdata_q <= rd_data;
            end
        end
    end

    // Config changes mid-packet take effect at once; software should wait
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            rate_q <= 2'h0;
            scr_dis_q <= 1'b0;
            wide_q <= 1'b0;
            rot_tx_q <= 1'b0;
            rot_rx_q <= 1'b0;
            short_q <= 1'b0;
            short_len_q <= `DSTX_RST_SHORT_LEN;
            long_len_q <= `DSTX_RST_LONG_LEN;
            service_q <= 8'h00;
            length_q <= 16'h0000;
            long_seed_q <= `DSTX_RST_LONG_SEED;
            short_seed_q <= `DSTX_RST_SHORT_SEED;
        end
        else if (apb_wr)
        begin
            case (PADDR)
                `DSTX_OFS_CTRL:
                begin
                    rate_q <= PWDATA[`DSTX_CTRL_RATE_LSB +: 2];
                    scr_dis_q <= PWDATA[`DSTX_CTRL_SCR_DIS];
                    wide_q <= PWDATA[`DSTX_CTRL_WIDE];
                    rot_tx_q <= PWDATA[`DSTX_CTRL_ROT_TX];
                    rot_rx_q <= PWDATA[`DSTX_CTRL_ROT_RX];
                    short_q <= PWDATA[`DSTX_CTRL_SHORT];
                end
                `DSTX_OFS_SHORT_LEN: short_len_q <= PWDATA[7:0];
                `DSTX_OFS_LONG_LEN: long_len_q <= PWDATA[7:0];
                `DSTX_OFS_SERVICE: service_q <= PWDATA[7:0];
                `DSTX_OFS_LENGTH: length_q <= PWDATA[15:0];
                `DSTX_OFS_SEED:
                begin
                    long_seed_q <= PWDATA[6:0];
                    short_seed_q <= PWDATA[`DSTX_SEED_SHORT_LSB +: 7];
                end
                default: ;
            endcase
        end
    end

    // Pin inputs through two flops
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            en_m_q <= 1'b0;
            en_s_q <= 1'b0;
            en_d_q <= 1'b0;
            dat_m_q <= 1'b0;
            dat_s_q <= 1'b0;
        end
        else
        begin
            en_m_q <= TX_ENABLE_LINE;
            en_s_q <= en_m_q;
            en_d_q <= en_s_q;
            dat_m_q <= TX_DATA;
            dat_s_q <= dat_m_q;
        end
    end

    // Modulation per packet part
    always_comb
    begin
        case (state_q)
            ST_HDR: mode = short_q ? MD_DQPSK : MD_DBPSK;
            ST_DATA, ST_TAIL: mode = dstx_mode_type'(rate_q);
            default: mode = MD_DBPSK;
        endcase
        case (mode)
            MD_DBPSK: nlast = 3'd0;
            MD_DQPSK: nlast = 3'd1;
            MD_CCK55: nlast = 3'd3;
            default: nlast = 3'd7;
        endcase
        case (rate_q)
            2'b00: sig_code = `DSTX_SIG_1M;
            2'b01: sig_code = `DSTX_SIG_2M;
            2'b10: sig_code = `DSTX_SIG_5M5;
            default: sig_code = `DSTX_SIG_11M;
        endcase
    end
    assign cck = mode[1];
    assign clast = cck ? `DSTX_CCK_LAST : `DSTX_BARKER_LAST;
    assign hdr_word = {length_q, service_q, sig_code};
    assign start = (state_q == ST_IDLE) & en_s_q & ~en_d_q;
    assign gathering = (state_q != ST_IDLE) & ~enc_q & ~send_q;
    assign take = gathering & ((state_q != ST_DATA) | (wait_q == 3'd1));
    assign sym_end = send_q & (chip_q == clast);

    // Bit source, fields LSB first, header check MSB first
    always_comb
    begin
        case (state_q)
            ST_PRE: raw = ~short_q;
            ST_SFD: raw = short_q ? sfd_short_code[bidx_q[3:0]]
                : sfd_long_code[bidx_q[3:0]];
            ST_HDR: raw = (bidx_q < `DSTX_HDR_PROT_BITS)
                ? hdr_word[bidx_q[4:0]]
                : ~crc_q[4'hf - bidx_q[3:0]];
            ST_DATA: raw = dat_s_q;
            default: raw = 1'b0;
        endcase
    end

    // Scrambler output bit and header check update
    assign sbit = scr_dis_q ? raw : (raw ^ scr_q[3] ^ scr_q[6]);
    assign crc_next = {crc_q[14:0], 1'b0}
        ^ ((crc_q[15] ^ raw) ? `DSTX_CRC_POLY : 16'h0000);

    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            scr_q <= 7'h00;
            crc_q <= `DSTX_CRC_PRESET;
        end
        else if (start)
        begin
            scr_q <= short_q ? short_seed_q : long_seed_q;
            crc_q <= `DSTX_CRC_PRESET;
        end
        else if (take)
        begin
            scr_q <= {scr_q[5:0], sbit};
            if (state_q == ST_HDR && bidx_q < `DSTX_HDR_PROT_BITS)
            begin
                crc_q <= crc_next;
            end
        end
    end

    // Data bit request: pulse, then sample after the synchroniser delay
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            req_q <= 1'b0;
            wait_q <= 3'h0;
        end
        else if (gathering && state_q == ST_DATA)
        begin
            req_q <= (wait_q == 3'h0);
            wait_q <= (wait_q == 3'h0) ? 3'(DATA_WAIT) : wait_q - 3'h1;
        end
        else
        begin
            req_q <= 1'b0;
            wait_q <= 3'h0;
        end
    end

    // Sequencer: gather symbol bits, encode, send chips, switch parts
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            state_q <= ST_IDLE;
            bidx_q <= 9'h000;
            gcnt_q <= 3'h0;
            sym_q <= 8'h00;
            enc_q <= 1'b0;
            send_q <= 1'b0;
            chip_q <= 4'h0;
        end
        else if (start)
        begin
            state_q <= ST_PRE;
            bidx_q <= 9'h000;
            gcnt_q <= 3'h0;
        end
        else if (take)
        begin
            sym_q[gcnt_q] <= sbit;
            bidx_q <= bidx_q + 9'h001;
            gcnt_q <= (gcnt_q == nlast) ? 3'h0 : gcnt_q + 3'h1;
            enc_q <= (gcnt_q == nlast);
        end
        else if (enc_q)
        begin
            enc_q <= 1'b0;
            send_q <= 1'b1;
            chip_q <= 4'h0;
        end
        else if (send_q)
        begin
            chip_q <= chip_q + 4'h1;
            if (sym_end)
            begin
                send_q <= 1'b0;
                case (state_q)
                    ST_PRE:
                        if (bidx_q >= {1'b0, short_q ? short_len_q
                            : long_len_q})
                        begin
                            state_q <= ST_SFD;
                            bidx_q <= 9'h000;
                        end
                    ST_SFD:
                        if (bidx_q == `DSTX_SFD_BITS)
                        begin
                            state_q <= ST_HDR;
                            bidx_q <= 9'h000;
                        end
                    ST_HDR:
                        if (bidx_q == `DSTX_HDR_BITS)
                        begin
                            state_q <= en_s_q ? ST_DATA : ST_TAIL;
                            bidx_q <= 9'h000;
                        end
                    ST_DATA:
                        if (!en_s_q)
                        begin
                            state_q <= ST_TAIL;
                            bidx_q <= 9'h000;
                        end
                    ST_TAIL:
                        if (bidx_q >= 9'(TAIL_BITS))
                        begin
                            state_q <= ST_IDLE;
                        end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Differential phase step of the symbol just gathered
    assign dq = {sym_q[0], sym_q[0] ^ sym_q[1]};
    always_comb
    begin
        case (mode)
            MD_DBPSK: delta = {sym_q[0], 1'b0};
            MD_DQPSK: delta = dq;
            default: delta = dq + {odd_q, 1'b0};
        endcase
        if (rot_tx_q)
        begin
            delta = 2'b00 - delta;
        end
    end

    // One phase register serves every mode, so CCK picks up its reference
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            ph_q <= 2'h0;
            odd_q <= 1'b0;
        end
        else if (start)
        begin
            // Phase from an earlier packet would split the DBPSK rails
            ph_q <= 2'h0;
        end
        else if (sym_end && state_q == ST_HDR)
        begin
            odd_q <= 1'b0;
        end
        else if (enc_q)
        begin
            ph_q <= ph_q + delta;
            if (cck)
            begin
                odd_q <= ~odd_q;
            end
        end
    end

    // CCK phases 2 to 4
    always_comb
    begin
        if (mode == MD_CCK55)
        begin
            p2 = {sym_q[2], 1'b1};
            p3 = 2'h0;
            p4 = {sym_q[3], 1'b0};
        end
        else
        begin
            p2 = {sym_q[2], sym_q[3]};
            p3 = {sym_q[4], sym_q[5]};
            p4 = {sym_q[6], sym_q[7]};
        end
        if (cck)
        begin
            chip_ph = ph_q + (chip_q[0] ? 2'h0 : p2)
                + (chip_q[1] ? 2'h0 : p3)
                + (chip_q[2] ? 2'h0 : p4)
                + ((chip_q == 4'h3 || chip_q == 4'h6) ? 2'h2 : 2'h0);
        end
        else
        begin
            chip_ph = ph_q + (barker_code[chip_q] ? 2'h0 : 2'h2);
        end
    end

    // Chip signs, first chip of each symbol first
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            ci_q <= 1'b0;
            cq_q <= 1'b0;
            cv_q <= 1'b0;
            active_q <= 1'b0;
        end
        else
        begin
            ci_q <= ~(chip_ph[1] ^ chip_ph[0]);
            cq_q <= ~chip_ph[1];
            cv_q <= send_q;
            active_q <= (state_q != ST_IDLE);
        end
    end

    // Four-tap symmetric FIR per rail
    function automatic logic signed [OUT_W-1:0] fir_sum(
        input logic signed [1:0] x0,
        input logic signed [1:0] x1,
        input logic signed [1:0] x2,
        input logic signed [1:0] x3,
        input logic wide);
        logic signed [OUT_W-1:0] c0;
        logic signed [OUT_W-1:0] c1;
        c0 = wide ? OUT_W'(`DSTX_FIR_W0) : OUT_W'(`DSTX_FIR_N0);
        c1 = wide ? OUT_W'(`DSTX_FIR_W1) : OUT_W'(`DSTX_FIR_N1);
        fir_sum = c0 * x0 + c1 * x1 + c1 * x2 + c0 * x3;
    endfunction

    assign xi0 = cv_q ? (ci_q ? 2'sh1 : -2'sh1) : 2'sh0;
    assign xq0 = cv_q ? (cq_q ? 2'sh1 : -2'sh1) : 2'sh0;

    // Wide shape costs output power through its larger peak
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            for (int k = 0; k < 3; k++)
            begin
                hi_q[k] <= 2'sh0;
                hq_q[k] <= 2'sh0;
            end
            i_q <= '0;
            q_q <= '0;
        end
        else
        begin
            hi_q[0] <= xi0;
            hq_q[0] <= xq0;
            for (int k = 1; k < 3; k++)
            begin
                hi_q[k] <= hi_q[k-1];
                hq_q[k] <= hq_q[k-1];
            end
            i_q <= fir_sum(xi0, hi_q[0], hi_q[1], hi_q[2], wide_q);
            q_q <= fir_sum(xq0, hq_q[0], hq_q[1], hq_q[2], wide_q);
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign TX_BIT_REQ = req_q;
    assign TX_ACTIVE = active_q;
    assign TX_I = i_q;
    assign TX_Q = q_q;
    assign TX_CHIP_VALID = cv_q;

    default clocking dcb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    // Chip run length, counted so the long Barker run is not unrolled
    logic [3:0] run_q;
    logic run_cck_q;
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            run_q <= 4'h0;
            run_cck_q <= 1'b0;
        end
        else
        begin
            run_q <= send_q ? run_q + 4'h1 : 4'h0;
            if (!send_q)
            begin
                run_cck_q <= cck;
            end
        end
    end

    sequence s_barker_end;
        $fell(send_q) && !run_cck_q;
    endsequence
    sequence s_cck_sym;
        send_q [*8] ##1 !send_q;
    endsequence

    a_req_single_pulse: assert property (TX_BIT_REQ |=> !TX_BIT_REQ)
        else $error("data request longer than one cycle");
    a_start_to_pre: assert property (start |=> state_q == ST_PRE)
        else $error("packet start did not enter preamble");
    a_pre_bit_value: assert property (take && state_q == ST_PRE
        |-> raw == ~short_q)
        else $error("preamble bit value wrong");
    a_scr_bypass: assert property (take && scr_dis_q |-> sbit == raw)
        else $error("scrambler not bypassed");
    a_scr_taps: assert property (take && !scr_dis_q && !start
        |=> scr_q[0] == ($past(raw) ^ $past(scr_q[3]) ^ $past(scr_q[6])))
        else $error("scrambler feedback wrong");
    a_barker_len: assert property (s_barker_end |-> run_q == 4'hb)
        else $error("Barker symbol not eleven chips");
    a_cck_len: assert property ($rose(send_q) && cck |-> s_cck_sym)
        else $error("CCK symbol not eight chips");
    a_dbpsk_same: assert property (send_q && mode == MD_DBPSK
        && !ph_q[0] |=> ci_q == cq_q)
        else $error("DBPSK rails differ");
    a_cck_last_chip: assert property (send_q && cck
        && chip_q == `DSTX_CCK_LAST
        |=> ci_q == ~($past(ph_q[1]) ^ $past(ph_q[0]))
            && cq_q == ~$past(ph_q[1]))
        else $error("last CCK chip not at phase1");
    a_crc_preset: assert property (start |=> crc_q == `DSTX_CRC_PRESET)
        else $error("header check not preset");
    a_odd_reset: assert property (sym_end && state_q == ST_HDR
        |=> !odd_q)
        else $error("odd symbol count not cleared");
endmodule

// ===== tb/dstx_ctrl_model.sv
// Behavioural transmit controller feeding payload bits to the modulator
`timescale 1ns/1ps
module dstx_ctrl_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench control
    input wire logic start,
    input wire logic [7:0] n_bits,
    output logic [7:0] req_cnt,
    // Modulator side
    input wire logic bit_req,
    output logic tx_en,
    output logic tx_bit
);
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx_en <= 1'b0;
            tx_bit <= 1'b0;
            req_cnt <= 8'h00;
        end
        else if (start)
        begin
            tx_en <= 1'b1;
            req_cnt <= 8'h00;
        end
        else if (bit_req)
        begin
            // Every request is counted, also a stray one after the drop
            tx_bit <= req_cnt[0] ^ req_cnt[2];
            req_cnt <= req_cnt + 8'h01;
            if (req_cnt + 8'h01 == n_bits)
                tx_en <= 1'b0;
        end
        else if (!tx_en)
            tx_bit <= ~tx_bit; // Released line must not look held
    end
endmodule

// ===== tb/testbench.sv
// Self-checking bench: register access and whole packets at every rate
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0, rst = 1'b1, start = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, tx_en, tx_bit, bit_req, tx_active, chip_v;
    logic [7:0] req_cnt;
    logic signed [7:0] tx_i, tx_q;
    int failures = 0, n_checks = 0;
    always #50 sys_clk = ~sys_clk;
    dstx_modulator dstx_modulator_i (.SYS_CLK(sys_clk), .RST(rst),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TX_ENABLE_LINE(tx_en), .TX_DATA(tx_bit),
        .TX_BIT_REQ(bit_req), .TX_ACTIVE(tx_active), .TX_I(tx_i),
        .TX_Q(tx_q), .TX_CHIP_VALID(chip_v));
    dstx_ctrl_model dstx_ctrl_model_i (.clk(sys_clk), .rst(rst),
        .start(start), .n_bits(8'h10), .req_cnt(req_cnt),
        .bit_req(bit_req), .tx_en(tx_en), .tx_bit(tx_bit));
    task automatic test_done();
        if (failures == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int k;
        k = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        while (k < 20)
        begin
            @(posedge sys_clk);
            if (pready === 1'b1)
                break;
            k++;
        end
        if (k == 20)
        begin
            failures++;
            test_done();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic regs_scn();
        logic [31:0] q, rv[7];
        logic e;
        rv = '{32'h0, 32'h38, 32'h80, 32'h0, 32'h0, 32'h6c1b, 32'h0};
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0, q, e);
            chk(q, rv[i]);
        end
        apb(1'b0, 8'h1c, 32'h0, q, e);
        chk({q[30:0], e}, 32'h1); // Unmapped address is refused
        apb(1'b1, 8'h0c, 32'ha5, q, e);
        apb(1'b1, 8'h10, 32'h1234, q, e);
        apb(1'b0, 8'h0c, 32'h0, q, e);
        chk(q, 32'ha5);
        apb(1'b0, 8'h10, 32'h0, q, e);
        chk(q, 32'h1234);
        // Short sync fields keep each packet run brief
        apb(1'b1, 8'h04, 32'h4, q, e);
        apb(1'b1, 8'h08, 32'h4, q, e);
    endtask
    task automatic pkt_scn(input int r, input logic sh);
        logic [31:0] q, ctl;
        logic e;
        int chips, t, exp;
        chips = 0;
        t = 0;
        ctl = (32'(sh) << 8) | (32'(r % 2) << 6) | (32'(r / 2) << 5);
        apb(1'b1, 8'h00, ctl | (32'(sh) << 2) | 32'(r), q, e);
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        while (tx_active !== 1'b1 && t < 50)
        begin
            @(posedge sys_clk);
            t++;
        end
        while (tx_active === 1'b1 && t < 20000)
        begin
            @(posedge sys_clk);
            t++;
            chips += (chip_v === 1'b1) ? 1 : 0;
            if (r == 0 && !sh)
                chk(32'(tx_i), 32'(tx_q));
        end
        repeat (5)
        begin
            @(posedge sys_clk);
            chips += (chip_v === 1'b1) ? 1 : 0;
        end
        if (t >= 20000)
        begin
            failures++;
            test_done();
        end
        exp = 20 * 11 + (sh ? 24 : 48) * 11 + (24 >> r) * (r < 2 ? 11 : 8);
        chk(32'(chips), 32'(exp));
        chk({24'h0, req_cnt}, 32'h10);
    endtask
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        regs_scn();
        for (int r = 0; r < 4; r++)
        begin
            pkt_scn(r, 1'b0);
            pkt_scn(r, 1'b1);
        end
        test_done();
    end
endmodule
